// *** hw/rtcis_pkg.sv ***
package rtcis_pkg;

  // Clock and link timing
  localparam int CLK_MHZ       = 100;
  localparam int SCL_PERIOD_NS = 160;
  localparam int QTR_CYC       = SCL_PERIOD_NS * CLK_MHZ / 4000;
  localparam int PWRUP_NS      = 1000;
  localparam int PWRUP_CYC     = (PWRUP_NS * CLK_MHZ + 999) / 1000;

  // Identity value is arbitrary
  localparam logic [6:0] DEV_ID = 7'h55;
  localparam logic       DIR_RD = 1'b1;
  localparam logic       DIR_WR = 1'b0;

  // Register array shape
  localparam int         REG_CNT   = 32;
  localparam int         PTR_W     = 5;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [3:0] ACK_BIT   = 4'h8;

  typedef enum logic [2:0] {
    D_IDLE, D_ID, D_REG, D_WDAT, D_ACK, D_RDAT, D_RACK
  } rtcis_dst_t;

  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} rtcis_mst_t;

  typedef enum logic [2:0] {S_IDW, S_REG, S_WDAT, S_IDR, S_RDAT} rtcis_step_t;

endpackage

// *** hw/rtcis_bus_if.sv ***
`timescale 1ns/10ps
interface rtcis_bus_if;
  logic scl_mst_o;
  logic scl_mst_oe;
  logic sda_mst_o;
  logic sda_mst_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // Wire levels with pull-ups: SDA is wired-AND of both drivers
  assign scl = scl_mst_oe ? scl_mst_o : 1'b1;
  assign sda = !((sda_mst_oe && !sda_mst_o) || (sda_dev_oe && !sda_dev_o));

  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport mst (input scl, input sda, output scl_mst_o, output scl_mst_oe,
               output sda_mst_o, output sda_mst_oe);
endinterface

// *** hw/rtcis_device.sv ***
// Functional notes
// - Device is slave only, never drives SCL
// - Bytes shift most significant bit first
// - SDA changes only while SCL is low
// - SDA released after power-up
// - Ignore bus until START seen
// - Ignore START during power-up sequence
// - STOP returns device to standby
// - Receiver pulls SDA low on ninth clock
// - Ack identifier, address and write data bytes
// - Master acks read bytes wanting more
// - Compare upper seven bits with identifier
// - Address LSB one reads, zero writes
// - Register address byte loads the pointer
// - Pointer clears to zero at power-up
// - Same identifier in both random-read phases
// - Write is id, address, data, STOP
// - Read uses repeated START with direction one
// - Send bytes while master keeps acking
// - Read from pointer, advance per byte
// - Pointer wraps from top to zero
`timescale 1ns/10ps
module rtcis_device (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  rtcis_bus_if.dev         bus,
  input  wire logic [4:0]  peek_index,
  output logic      [7:0]  peek_data,
  output logic             wr_strobe,
  output logic      [4:0]  wr_index,
  output logic      [7:0]  wr_data
);

  logic [7:0] mem [rtcis_pkg::REG_CNT];

  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic rise, fall, start, stop;

  rtcis_pkg::rtcis_dst_t st_r, st_nxt, after_r, after_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic        full_r, full_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic [rtcis_pkg::PTR_W-1:0] ptr_r, ptr_nxt;
  logic        oe_r, oe_nxt;
  logic        mack_r, mack_nxt;
  logic [7:0]  pwr_cnt_r, pwr_cnt_nxt;
  logic        pwr_done_r, pwr_done_nxt;
  logic        mem_we;
  logic [7:0]  peek_r, wr_data_r;
  logic [4:0]  wr_index_r;
  logic        wr_strobe_r, sda_o_r;

  // Two-stage synchronisers plus one delay stage for edge finding
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= bus.scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= bus.sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Line events
  assign rise  = scl_s_r & ~scl_d_r;
  assign fall  = ~scl_s_r & scl_d_r;
  assign start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // Power-up hold-off counter
  always_comb
  begin
    pwr_cnt_nxt  = pwr_cnt_r;
    pwr_done_nxt = pwr_done_r;
    if (!pwr_done_r)
    begin
      pwr_cnt_nxt = pwr_cnt_r + 8'h01;
      if (pwr_cnt_r == 8'(rtcis_pkg::PWRUP_CYC - 1))
        pwr_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pwr_cnt_r  <= 8'h00;
      pwr_done_r <= 1'b0;
    end
    else
    begin
      pwr_cnt_r  <= pwr_cnt_nxt;
      pwr_done_r <= pwr_done_nxt;
    end
  end

  // Protocol engine: sample on SCL rise, change SDA on SCL fall
  always_comb
  begin
    st_nxt    = st_r;
    after_nxt = after_r;
    cnt_nxt   = cnt_r;
    full_nxt  = full_r;
    sh_nxt    = sh_r;
    tx_nxt    = tx_r;
    ptr_nxt   = ptr_r;
    oe_nxt    = oe_r;
    mack_nxt  = mack_r;
    mem_we    = 1'b0;
    if (!pwr_done_r)
    begin
      st_nxt = rtcis_pkg::D_IDLE;
      oe_nxt = 1'b0;
    end
    else if (start)
    begin
      st_nxt   = rtcis_pkg::D_ID;
      cnt_nxt  = 3'h0;
      full_nxt = 1'b0;
      oe_nxt   = 1'b0;
    end
    else if (stop)
    begin
      st_nxt = rtcis_pkg::D_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (st_r)
        rtcis_pkg::D_IDLE: ;
        rtcis_pkg::D_ID, rtcis_pkg::D_REG, rtcis_pkg::D_WDAT:
        begin
          if (rise)
          begin
            sh_nxt  = {sh_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == rtcis_pkg::LAST_BIT)
              full_nxt = 1'b1;
          end
          if (fall && full_r)
          begin
            full_nxt = 1'b0;
            st_nxt   = rtcis_pkg::D_ACK;
            oe_nxt   = 1'b1;
            if (st_r == rtcis_pkg::D_ID)
            begin
              if (sh_r[7:1] != rtcis_pkg::DEV_ID)
              begin
                st_nxt = rtcis_pkg::D_IDLE;
                oe_nxt = 1'b0;
              end
              after_nxt = (sh_r[0] == rtcis_pkg::DIR_RD) ?
                          rtcis_pkg::D_RDAT : rtcis_pkg::D_REG;
            end
            else if (st_r == rtcis_pkg::D_REG)
            begin
              ptr_nxt   = sh_r[4:0];
              after_nxt = rtcis_pkg::D_WDAT;
            end
            else
            begin
              mem_we    = 1'b1;
              ptr_nxt   = ptr_r + 5'h01;
              after_nxt = rtcis_pkg::D_WDAT;
            end
          end
        end
        rtcis_pkg::D_ACK:
        begin
          if (fall)
          begin
            oe_nxt  = 1'b0;
            st_nxt  = after_r;
            cnt_nxt = 3'h0;
            if (after_r == rtcis_pkg::D_RDAT)
            begin
              tx_nxt  = mem[ptr_r];
              oe_nxt  = ~mem[ptr_r][7];
              ptr_nxt = ptr_r + 5'h01;
            end
          end
        end
        rtcis_pkg::D_RDAT:
        begin
          if (fall)
          begin
            if (cnt_r == rtcis_pkg::LAST_BIT)
            begin
              oe_nxt = 1'b0;
              st_nxt = rtcis_pkg::D_RACK;
            end
            else
            begin
              tx_nxt  = {tx_r[6:0], 1'b0};
              oe_nxt  = ~tx_r[6];
              cnt_nxt = cnt_r + 3'h1;
            end
          end
        end
        rtcis_pkg::D_RACK:
        begin
          if (rise)
            mack_nxt = ~sda_s_r;
          if (fall)
          begin
            cnt_nxt = 3'h0;
            if (mack_r)
            begin
              st_nxt  = rtcis_pkg::D_RDAT;
              tx_nxt  = mem[ptr_r];
              oe_nxt  = ~mem[ptr_r][7];
              ptr_nxt = ptr_r + 5'h01;
            end
            else
              st_nxt = rtcis_pkg::D_IDLE;
          end
        end
        default: st_nxt = rtcis_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r    <= rtcis_pkg::D_IDLE;
      after_r <= rtcis_pkg::D_REG;
      cnt_r   <= 3'h0;
      full_r  <= 1'b0;
      sh_r    <= 8'h00;
      tx_r    <= 8'h00;
      ptr_r   <= rtcis_pkg::PTR_RESET;
      oe_r    <= 1'b0;
      mack_r  <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      after_r <= after_nxt;
      cnt_r   <= cnt_nxt;
      full_r  <= full_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      ptr_r   <= ptr_nxt;
      oe_r    <= oe_nxt;
      mack_r  <= mack_nxt;
    end
  end

  // Register array and user-side ports
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      mem[ptr_r] <= sh_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      peek_r      <= 8'h00;
      wr_strobe_r <= 1'b0;
      wr_index_r  <= 5'h00;
      wr_data_r   <= 8'h00;
      sda_o_r     <= 1'b0;
    end
    else
    begin
      peek_r      <= mem[peek_index];
      wr_strobe_r <= mem_we;
      wr_index_r  <= mem_we ? ptr_r : wr_index_r;
      wr_data_r   <= mem_we ? sh_r : wr_data_r;
      sda_o_r     <= 1'b0;
    end
  end

  // Open-drain SDA; no SCL driver exists on this end
  assign bus.sda_dev_o  = sda_o_r;
  assign bus.sda_dev_oe = oe_r;
  assign peek_data      = peek_r;
  assign wr_strobe      = wr_strobe_r;
  assign wr_index       = wr_index_r;
  assign wr_data        = wr_data_r;

endmodule

// *** hw/rtcis_master.sv ***
`timescale 1ns/10ps
module rtcis_master (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  rtcis_bus_if.mst         bus,
  input  wire logic        req,
  input  wire logic        req_rd,
  input  wire logic [7:0]  req_reg,
  input  wire logic [7:0]  req_wdata,
  input  wire logic [5:0]  req_len,
  output logic             busy,
  output logic             rd_valid,
  output logic      [7:0]  rd_data,
  output logic             done,
  output logic             nack_err
);

  rtcis_pkg::rtcis_mst_t  st_r, st_nxt;
  rtcis_pkg::rtcis_step_t step_r, step_nxt;
  logic [1:0] q_r, q_nxt;
  logic [7:0] qcnt_r, qcnt_nxt;
  logic       tick;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic       tx_r, tx_nxt, rd_r, rd_nxt;
  logic [7:0] reg_r, reg_nxt, wd_r, wd_nxt;
  logic [5:0] left_r, left_nxt;
  logic       scl_r, scl_nxt, oe_r, oe_nxt;
  logic       busy_r, busy_nxt, err_r, err_nxt;
  logic       rv_r, rv_nxt, done_r, done_nxt;
  logic [7:0] rdd_r, rdd_nxt;
  logic       sda_m_r, sda_s_r;

  // Two-stage synchroniser for SDA
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end
    else
    begin
      sda_m_r <= bus.sda;
      sda_s_r <= sda_m_r;
    end
  end

  assign tick = (qcnt_r == 8'(rtcis_pkg::QTR_CYC - 1));

  // Quarter-period sequencer for START, bytes and STOP
  always_comb
  begin
    st_nxt   = st_r;
    step_nxt = step_r;
    q_nxt    = q_r;
    qcnt_nxt = tick ? 8'h00 : qcnt_r + 8'h01;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    tx_nxt   = tx_r;
    rd_nxt   = rd_r;
    reg_nxt  = reg_r;
    wd_nxt   = wd_r;
    left_nxt = left_r;
    scl_nxt  = scl_r;
    oe_nxt   = oe_r;
    busy_nxt = busy_r;
    err_nxt  = err_r;
    rdd_nxt  = rdd_r;
    rv_nxt   = 1'b0;
    done_nxt = 1'b0;
    if (st_r == rtcis_pkg::M_IDLE)
    begin
      qcnt_nxt = 8'h00;
      q_nxt    = 2'h0;
      if (req)
      begin
        st_nxt   = rtcis_pkg::M_START;
        step_nxt = rtcis_pkg::S_IDW;
        rd_nxt   = req_rd;
        reg_nxt  = req_reg;
        wd_nxt   = req_wdata;
        left_nxt = (req_len == 6'h00) ? 6'h01 : req_len;
        busy_nxt = 1'b1;
        err_nxt  = 1'b0;
      end
    end
    else if (tick)
    begin
      q_nxt = q_r + 2'h1;
      unique case (st_r)
        rtcis_pkg::M_START:
          unique case (q_r)
            2'h0: oe_nxt  = 1'b0;
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt  = 1'b1;
            2'h3:
            begin
              scl_nxt = 1'b0;
              st_nxt  = rtcis_pkg::M_BYTE;
              bit_nxt = 4'h0;
              tx_nxt  = 1'b1;
              sh_nxt  = {rtcis_pkg::DEV_ID,
                         (step_r == rtcis_pkg::S_IDR) ?
                         rtcis_pkg::DIR_RD : rtcis_pkg::DIR_WR};
            end
          endcase
        rtcis_pkg::M_BYTE:
          unique case (q_r)
            2'h0:
              if (bit_r != rtcis_pkg::ACK_BIT)
                oe_nxt = tx_r & ~sh_r[7];
              else
                oe_nxt = ~tx_r & (left_r != 6'h01);
            2'h1: scl_nxt = 1'b1;
            2'h2:
              if (bit_r != rtcis_pkg::ACK_BIT)
              begin
                if (!tx_r)
                  sh_nxt = {sh_r[6:0], sda_s_r};
              end
              else if (tx_r && sda_s_r)
                err_nxt = 1'b1;
            2'h3:
            begin
              scl_nxt = 1'b0;
              bit_nxt = bit_r + 4'h1;
              if (bit_r != rtcis_pkg::ACK_BIT)
              begin
                if (tx_r)
                  sh_nxt = {sh_r[6:0], 1'b0};
              end
              else if (err_r)
                st_nxt = rtcis_pkg::M_STOP;
              else
              begin
                bit_nxt = 4'h0;
                unique case (step_r)
                  rtcis_pkg::S_IDW:
                  begin
                    step_nxt = rtcis_pkg::S_REG;
                    sh_nxt   = reg_r;
                  end
                  rtcis_pkg::S_REG:
                    if (rd_r)
                    begin
                      st_nxt   = rtcis_pkg::M_START;
                      step_nxt = rtcis_pkg::S_IDR;
                    end
                    else
                    begin
                      step_nxt = rtcis_pkg::S_WDAT;
                      sh_nxt   = wd_r;
                    end
                  rtcis_pkg::S_WDAT: st_nxt = rtcis_pkg::M_STOP;
                  rtcis_pkg::S_IDR:
                  begin
                    step_nxt = rtcis_pkg::S_RDAT;
                    tx_nxt   = 1'b0;
                  end
                  rtcis_pkg::S_RDAT:
                  begin
                    rv_nxt   = 1'b1;
                    rdd_nxt  = sh_r;
                    left_nxt = left_r - 6'h01;
                    if (left_r == 6'h01)
                      st_nxt = rtcis_pkg::M_STOP;
                  end
                  default: st_nxt = rtcis_pkg::M_STOP;
                endcase
              end
            end
          endcase
        rtcis_pkg::M_STOP:
          unique case (q_r)
            2'h0: oe_nxt  = 1'b1;
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt  = 1'b0;
            2'h3:
            begin
              st_nxt   = rtcis_pkg::M_IDLE;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
            end
          endcase
        rtcis_pkg::M_IDLE: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r   <= rtcis_pkg::M_IDLE;
      step_r <= rtcis_pkg::S_IDW;
      q_r    <= 2'h0;
      qcnt_r <= 8'h00;
      bit_r  <= 4'h0;
      sh_r   <= 8'h00;
      tx_r   <= 1'b1;
      rd_r   <= 1'b0;
      reg_r  <= 8'h00;
      wd_r   <= 8'h00;
      left_r <= 6'h00;
      scl_r  <= 1'b1;
      oe_r   <= 1'b0;
      busy_r <= 1'b0;
      err_r  <= 1'b0;
      rv_r   <= 1'b0;
      done_r <= 1'b0;
      rdd_r  <= 8'h00;
    end
    else
    begin
      st_r   <= st_nxt;
      step_r <= step_nxt;
      q_r    <= q_nxt;
      qcnt_r <= qcnt_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      tx_r   <= tx_nxt;
      rd_r   <= rd_nxt;
      reg_r  <= reg_nxt;
      wd_r   <= wd_nxt;
      left_r <= left_nxt;
      scl_r  <= scl_nxt;
      oe_r   <= oe_nxt;
      busy_r <= busy_nxt;
      err_r  <= err_nxt;
      rv_r   <= rv_nxt;
      done_r <= done_nxt;
      rdd_r  <= rdd_nxt;
    end
  end

  // Master drives SCL push-pull; SDA is open drain (oe pulls low)
  assign bus.scl_mst_o  = scl_r;
  assign bus.scl_mst_oe = rst_n;
  assign bus.sda_mst_o  = 1'b0;
  assign bus.sda_mst_oe = oe_r;
  assign busy           = busy_r;
  assign rd_valid       = rv_r;
  assign rd_data        = rdd_r;
  assign done           = done_r;
  assign nack_err       = err_r;

endmodule

// *** tb/rtcis_monitor.sv ***
`timescale 1ns/10ps
module rtcis_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_mst_o,
  input wire logic scl_mst_oe,
  input wire logic sda_mst_o,
  input wire logic sda_mst_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic       first_r;
  logic       first_nxt;
  logic       wr_dir_r;
  logic       wr_dir_nxt;
  logic       quiet_r;
  logic       quiet_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic       rise;
  logic       start;
  logic       stop;
  logic [7:0] up_r;
  logic       up_done;

  // Device power-up window: STARTs inside it must be ignored
  assign up_done = (up_r == 8'(rtcis_pkg::PWRUP_CYC));

  // Clock rise, START and STOP seen on the resolved wires
  assign rise  = scl && !scl_q_r;
  assign start = scl && scl_q_r && sda_q_r && !sda;
  assign stop  = scl && scl_q_r && !sda_q_r && sda;

  // Bit count, first byte and write direction since the last START
  always_comb
  begin
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    first_nxt  = first_r;
    wr_dir_nxt = wr_dir_r;
    quiet_nxt  = quiet_r;
    if (rise)
    begin
      sh_nxt  = {sh_r[6:0], sda};
      cnt_nxt = (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
      if (cnt_r == 4'h8 && first_r)
        wr_dir_nxt = !sh_r[0] && sda_dev_oe;
      if (cnt_r == 4'h9)
        first_nxt = 1'b0;
    end
    if (start || stop)
    begin
      cnt_nxt    = 4'h0;
      first_nxt  = 1'b1;
      wr_dir_nxt = 1'b0;
      quiet_nxt  = stop || !up_done;
    end
  end

  // Register the tracking state; idle until a START after the power-up window
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      first_r  <= 1'b1;
      wr_dir_r <= 1'b0;
      quiet_r  <= 1'b1;
      up_r     <= 8'h00;
    end
    else
    begin
      up_r     <= up_done ? up_r : up_r + 8'h01;
      scl_q_r  <= scl;
      sda_q_r  <= sda;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      first_r  <= first_nxt;
      wr_dir_r <= wr_dir_nxt;
      quiet_r  <= quiet_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Rising clock of the acknowledge slot
  sequence s_ack_clk;
    rise && cnt_r == 4'h8;
  endsequence

  property p_quiet;
    quiet_r |-> !sda_dev_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("device drove sda while idle");

  property p_rst_rel;
    $rose(rst_n) |-> !sda_dev_oe && !sda_mst_oe;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("sda not released after reset");

  property p_id_ack;
    s_ack_clk ##0 first_r && !quiet_r |->
      sda_dev_oe == (sh_r[7:1] == rtcis_pkg::DEV_ID);
  endproperty
  a_id_ack: assert property (p_id_ack)
    else $error("identifier acknowledge wrong");

  property p_wr_ack;
    s_ack_clk ##0 wr_dir_r |-> sda_dev_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");

  property p_ack_slot;
    (first_r || wr_dir_r) && sda_dev_oe |-> cnt_r >= 4'h8;
  endproperty
  a_ack_slot: assert property (p_ack_slot)
    else $error("device drove sda outside the ack slot");

  property p_ack_release;
    s_ack_clk ##0 ((first_r && !sh_r[0]) || wr_dir_r) |-> ##[8:20] !sda_dev_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge not released");

  property p_mst_release;
    s_ack_clk ##0 (first_r || wr_dir_r) |-> !sda_mst_oe;
  endproperty
  a_mst_release: assert property (p_mst_release)
    else $error("master held sda in ack slot");

  property p_dev_scl_low;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low)
    else $error("device changed sda while scl high");

  property p_mst_stable;
    scl && scl_q_r && cnt_r inside {[4'h2:4'h9]} |-> $stable(sda_mst_oe);
  endproperty
  a_mst_stable: assert property (p_mst_stable)
    else $error("master changed sda while scl high");

  property p_open_drain;
    !sda_dev_o && !sda_mst_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda driven high by a port");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic       rd;
    logic [7:0] rg;
    logic [7:0] wd;
    logic [5:0] len;
    logic [7:0] ex;
  } rtcis_row_t;

  logic       clk_sys    = 1'b0;
  logic       rst_n      = 1'b0;
  logic       req        = 1'b0;
  logic       req_rd     = 1'b0;
  logic [7:0] req_reg    = 8'h00;
  logic [7:0] req_wdata  = 8'h00;
  logic [5:0] req_len    = 6'h01;
  logic [4:0] peek_index = 5'h00;
  logic [7:0] peek_data;
  logic       wr_strobe;
  logic [4:0] wr_index;
  logic [7:0] wr_data;
  logic [4:0] b_index;
  logic [7:0] b_data;
  logic       busy;
  logic       rd_valid;
  logic       done;
  logic       nack_err;
  logic [7:0] rd_data;
  logic       ack;
  int         errors  = 0;
  int         checks  = 0;
  int         strobes = 0;
  logic [7:0] exp_mem [32];
  rtcis_row_t rows [8] = '{
    '{1'h0, 8'h00, 8'ha5, 6'h01, 8'ha5},
    '{1'h0, 8'h1f, 8'h3c, 6'h01, 8'h3c},
    '{1'h0, 8'h10, 8'h5a, 6'h01, 8'h5a},
    '{1'h0, 8'h01, 8'hc3, 6'h01, 8'hc3},
    '{1'h0, 8'he2, 8'h81, 6'h01, 8'h81},
    '{1'h1, 8'h1f, 8'h00, 6'h04, 8'h3c},
    '{1'h1, 8'h00, 8'h00, 6'h01, 8'ha5},
    '{1'h1, 8'h01, 8'h00, 6'h02, 8'hc3}};

  rtcis_bus_if bus ();
  rtcis_bus_if bus2 ();

  rtcis_device u_rtcis_device (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .peek_index(peek_index), .peek_data(peek_data), .wr_strobe(wr_strobe),
    .wr_index(wr_index), .wr_data(wr_data));
  rtcis_master u_rtcis_master (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .req(req), .req_rd(req_rd), .req_reg(req_reg), .req_wdata(req_wdata),
    .req_len(req_len), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .nack_err(nack_err));
  rtcis_device u_rtcis_device_b (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(bus2), .peek_index(5'h00), .peek_data(), .wr_strobe(),
    .wr_index(b_index), .wr_data(b_data));
  rtcis_monitor u_rtcis_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
    .scl_mst_o(bus.scl_mst_o), .scl_mst_oe(bus.scl_mst_oe),
    .sda_mst_o(bus.sda_mst_o), .sda_mst_oe(bus.sda_mst_oe),
    .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe),
    .scl(bus.scl), .sda(bus.sda));

  // 100 MHz system clock
  always #5 clk_sys = !clk_sys;

  // Count write strobes of the main device
  always @(posedge clk_sys)
    if (wr_strobe === 1'b1)
      strobes++;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One full master transfer, read bytes compared as they arrive
  task automatic run(input rtcis_row_t r);
    logic [4:0] idx;
    logic [7:0] n;
    idx = r.rg[4:0];
    n = 8'h00;
    strobes = 0;
    if (!r.rd)
      exp_mem[idx] = r.wd;
    {req_rd, req_reg, req_wdata, req_len} = {r.rd, r.rg, r.wd, r.len};
    peek_index = idx;
    req = 1'b1;
    @(negedge clk_sys);
    req = 1'b0;
    repeat (4000)
    begin
      @(negedge clk_sys);
      if (rd_valid === 1'b1)
      begin
        chk(rd_data, exp_mem[idx], "rd_data");
        if (n == 8'h00)
          chk(rd_data, r.ex, "first byte");
        idx++;
        n++;
      end
      if (done === 1'b1)
        break;
    end
    chk({7'h00, done, nack_err}, 8'h02, "done");
    if (r.rd)
      chk(n, {2'h0, r.len}, "read count");
    else
    begin
      chk({3'h0, wr_index}, {3'h0, r.rg[4:0]}, "wr_index");
      chk(wr_data, r.wd, "wr_data");
      chk(peek_data, r.ex, "peek_data");
      chk(strobes[7:0], 8'h01, "strobes");
    end
  endtask

  // Second bus: one clock of the far side, data set while scl low
  task automatic bb_clk(input logic b, output logic s);
    bus2.scl_mst_o = 1'b0;
    repeat (6) @(negedge clk_sys);
    bus2.sda_mst_oe = !b;
    repeat (6) @(negedge clk_sys);
    bus2.scl_mst_o = 1'b1;
    repeat (4) @(negedge clk_sys);
    s = bus2.sda;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic bb_start();
    bb_clk(1'b1, ack);
    bus2.sda_mst_oe = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic bb_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bb_clk(b[i], ack);
    bb_clk(1'b1, ack);
    ack = !ack;
  endtask

  // Watchdog cuts a hang short
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end

  initial
  begin
    bus2.scl_mst_oe = 1'b1;
    bus2.scl_mst_o = 1'b1;
    bus2.sda_mst_o = 1'b0;
    bus2.sda_mst_oe = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    chk({3'h0, busy, done, nack_err, bus.sda, bus.scl}, 8'h03, "idle");
    bb_start();
    bb_byte({rtcis_pkg::DEV_ID, rtcis_pkg::DIR_WR});
    chk({7'h00, ack}, 8'h00, "early ack");
    bb_clk(1'b0, ack);
    bus2.sda_mst_oe = 1'b0;
    repeat (8) @(negedge clk_sys);
    bb_start();
    bb_byte({rtcis_pkg::DEV_ID ^ 7'h01, rtcis_pkg::DIR_WR});
    chk({7'h00, ack}, 8'h00, "wrong id ack");
    bb_start();
    bb_byte({rtcis_pkg::DEV_ID, rtcis_pkg::DIR_WR});
    chk({7'h00, ack}, 8'h01, "id ack");
    bb_byte(8'h03);
    chk({7'h00, ack}, 8'h01, "reg ack");
    bb_byte(8'h77);
    chk({7'h00, ack}, 8'h01, "data ack");
    chk({3'h0, b_index}, 8'h03, "b_index");
    chk(b_data, 8'h77, "b_data");
    for (int i = 0; i < 8; i++)
      run(rows[i]);
    req = 1'b1;
    @(negedge clk_sys);
    req = 1'b0;
    repeat (200) @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({6'h00, busy, bus.sda}, 8'h01, "reset lines");
    rst_n = 1'b1;
    // Request at once: START falls in the power-up window
    req = 1'b1;
    @(negedge clk_sys);
    req = 1'b0;
    repeat (400)
    begin
      @(negedge clk_sys);
      if (done === 1'b1)
        break;
    end
    chk({6'h00, done, nack_err}, 8'h03, "powerup nack");
    run(rows[0]);
    run(rows[6]);
    end_of_test();
  end
endmodule
